// *** verilog/qr_switch_sequencer.sv ***
// Switch sequencer: gate timing, fault bursts, overvoltage latch, APB registers
`timescale 1ns/10ps
module qr_switch_sequencer
#(
    parameter logic [15:0] RAMPS_PER_WINDOW = 16'h0800
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        zero_cross,
    input  wire logic        current_trip,
    input  wire logic        error_flag,
    input  wire logic        vcc_overvoltage,
    input  wire logic        overvoltage_trip,
    input  wire logic        startup_threshold,
    input  wire logic        stop_threshold,
    input  wire logic        takeover_high,
    input  wire logic        osc_pulse,
    input  wire logic        timing_capacitor_ramp,
    output logic             gate_drive,
    output logic             startup_source_on,
    output logic             cap_to_fault_timer,
    output logic             osc_freq_clamp,
    output logic             variable_frequency_mode
);
    logic [qr_seq_pkg::NUM_IN-1:0] raw;
    logic [qr_seq_pkg::NUM_IN-1:0] lvl;
    logic [qr_seq_pkg::NUM_IN-1:0] rise;

    qr_seq_pkg::seq_state_t   seq_reg;
    qr_seq_pkg::fault_state_t fault_reg;
    logic [31:0] ctrl_reg;
    logic [15:0] pulses_reg;
    logic [15:0] ramp_cnt_reg;
    logic [2:0]  win_cnt_reg;
    logic [7:0]  timeout_cnt_reg;
    logic [3:0]  blank_cnt_reg;
    logic        run_reg;
    logic        ov_latched_reg;
    logic        osc_latched_reg;
    logic        timeout_reg;
    logic        resume_reg;

    logic        zc_rise;
    logic        cur_lvl;
    logic        err_lvl;
    logic        start_rise;
    logic        stop_lvl;
    logic        ov_hit;
    logic        borderline_mode;
    logic        cap_event;
    logic        ramp_rise;
    logic        window_end;
    logic        pulse_allow;
    logic        start_now;
    logic        bus_access;

    // Comparator bundle into the sampler
    assign raw = {timing_capacitor_ramp, osc_pulse, takeover_high, stop_threshold,
                  startup_threshold, overvoltage_trip, vcc_overvoltage, error_flag,
                  current_trip, zero_cross};

    input_sampler u_sampler
    (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .raw     (raw),
        .level   (lvl),
        .rise    (rise)
    );

    // Decoded conditions
    assign zc_rise    = rise[qr_seq_pkg::IN_ZC];
    assign cur_lvl    = lvl[qr_seq_pkg::IN_CUR];
    assign err_lvl    = lvl[qr_seq_pkg::IN_ERR]; // RQ12
    assign start_rise = rise[qr_seq_pkg::IN_START];
    assign stop_lvl   = lvl[qr_seq_pkg::IN_STOP];
    assign ramp_rise  = rise[qr_seq_pkg::IN_RAMP];
    assign ov_hit     = lvl[qr_seq_pkg::IN_OVV] | lvl[qr_seq_pkg::IN_OVEXT]; // RQ17
    // An error relaxes the loop to natural borderline switching
    assign borderline_mode = lvl[qr_seq_pkg::IN_TAKE] | err_lvl; // RQ10
    // Capacitor event: oscillator pulse, or ramp while routed to the fault timer
    assign cap_event  = err_lvl ? ramp_rise : rise[qr_seq_pkg::IN_OSC]; // RQ3
    assign window_end = ramp_rise && (ramp_cnt_reg == RAMPS_PER_WINDOW - 16'h0001); // RQ11
    assign pulse_allow = run_reg && ctrl_reg[qr_seq_pkg::CTRL_EN] && !ov_latched_reg
                         && (fault_reg != qr_seq_pkg::F_SUPPRESS); // RQ8

    // Restart condition for a new on period
    always_comb
    begin
        start_now = 1'b0;
        if (seq_reg == qr_seq_pkg::S_IDLE && pulse_allow)
        begin
            if (borderline_mode && zc_rise)
                start_now = 1'b1; // RQ1
            else if (!borderline_mode && osc_latched_reg && zc_rise)
                start_now = 1'b1; // RQ2 RQ5
            else if (timeout_reg && cap_event)
                start_now = 1'b1; // RQ3
        end
    end

    // Supply run state and overvoltage latch
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_reg        <= 1'b0;
            ov_latched_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (!stop_lvl)
            begin
                run_reg        <= 1'b0; // RQ19
                ov_latched_reg <= 1'b0; // RQ16
            end
            else
            begin
                if (lvl[qr_seq_pkg::IN_START])
                    run_reg <= 1'b1;
                if (ov_hit)
                    ov_latched_reg <= 1'b1; // RQ15
            end
        end
    end

    // Startup current source hysteresis
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            startup_source_on <= qr_seq_pkg::STARTUP_SRC_RESET;
        else if (clk_en)
        begin
            if (!stop_lvl)
                startup_source_on <= 1'b1; // RQ14
            else if (lvl[qr_seq_pkg::IN_START])
                startup_source_on <= 1'b0; // RQ14
        end
    end

    // Oscillator pulse latch, set wins over clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            osc_latched_reg <= 1'b0;
        else if (clk_en)
        begin
            if (!borderline_mode && rise[qr_seq_pkg::IN_OSC])
                osc_latched_reg <= 1'b1; // RQ2
            else if (start_now || borderline_mode)
                osc_latched_reg <= 1'b0;
        end
    end

    // Demagnetization timeout restarted by every zero-cross
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            timeout_cnt_reg <= '0;
            timeout_reg     <= 1'b0;
        end
        else if (clk_en)
        begin
            if (!run_reg)
            begin
                timeout_cnt_reg <= '0;
                timeout_reg     <= 1'b0;
            end
            else if (zc_rise)
            begin
                timeout_cnt_reg <= qr_seq_pkg::TIMEOUT_CYC; // RQ3
                timeout_reg     <= 1'b0;
            end
            else if (timeout_cnt_reg != 8'h00)
            begin
                timeout_cnt_reg <= timeout_cnt_reg - 8'h01;
                if (timeout_cnt_reg == 8'h01)
                    timeout_reg <= 1'b1; // RQ3
            end
            else if (start_now)
                timeout_reg <= 1'b0;
        end
    end

    // Gate sequencing: idle, blanked on, sensed on
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            seq_reg       <= qr_seq_pkg::S_IDLE;
            gate_drive    <= 1'b0;
            blank_cnt_reg <= '0;
        end
        else if (clk_en)
        begin
            if (!pulse_allow)
            begin
                seq_reg    <= qr_seq_pkg::S_IDLE; // RQ15 RQ19
                gate_drive <= 1'b0;
            end
            else
            begin
                case (seq_reg)
                    qr_seq_pkg::S_IDLE:
                    begin
                        if (start_now)
                        begin
                            seq_reg       <= qr_seq_pkg::S_BLANK;
                            gate_drive    <= 1'b1;
                            blank_cnt_reg <= qr_seq_pkg::BLANK_CYC;
                        end
                    end
                    qr_seq_pkg::S_BLANK:
                    begin
                        blank_cnt_reg <= blank_cnt_reg - 4'h1; // RQ18
                        if (blank_cnt_reg == 4'h1)
                            seq_reg <= qr_seq_pkg::S_ON;
                    end
                    qr_seq_pkg::S_ON:
                    begin
                        if (cur_lvl)
                        begin
                            seq_reg    <= qr_seq_pkg::S_IDLE; // RQ6
                            gate_drive <= 1'b0;
                        end
                    end
                    default:
                    begin
                        seq_reg    <= qr_seq_pkg::S_IDLE;
                        gate_drive <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Fault window timing and burst suppression
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fault_reg    <= qr_seq_pkg::F_NORMAL;
            ramp_cnt_reg <= '0;
            win_cnt_reg  <= '0;
            resume_reg   <= 1'b0;
        end
        else if (clk_en)
        begin
            if (!run_reg && fault_reg != qr_seq_pkg::F_SUPPRESS)
            begin
                fault_reg    <= qr_seq_pkg::F_NORMAL; // RQ19
                ramp_cnt_reg <= '0;
                win_cnt_reg  <= '0;
                resume_reg   <= 1'b0;
            end
            else
            begin
                if (ramp_rise)
                    ramp_cnt_reg <= window_end ? 16'h0000 : ramp_cnt_reg + 16'h0001; // RQ11
                case (fault_reg)
                    qr_seq_pkg::F_NORMAL:
                    begin
                        ramp_cnt_reg <= '0;
                        if (err_lvl)
                            fault_reg <= qr_seq_pkg::F_TIMING;
                    end
                    qr_seq_pkg::F_TIMING:
                    begin
                        if (!err_lvl)
                            fault_reg <= qr_seq_pkg::F_NORMAL; // RQ13
                        else if (window_end)
                        begin
                            fault_reg   <= qr_seq_pkg::F_SUPPRESS; // RQ7
                            win_cnt_reg <= '0;
                            resume_reg  <= 1'b0;
                        end
                    end
                    qr_seq_pkg::F_SUPPRESS:
                    begin
                        if (!err_lvl)
                            resume_reg <= 1'b1;
                        if ((resume_reg || !err_lvl) && start_rise)
                            fault_reg <= qr_seq_pkg::F_NORMAL; // RQ9
                        else if (window_end)
                        begin
                            win_cnt_reg <= win_cnt_reg + 3'h1;
                            if (win_cnt_reg == qr_seq_pkg::SUPPRESS_LAST)
                                fault_reg <= err_lvl ? qr_seq_pkg::F_TIMING
                                                     : qr_seq_pkg::F_NORMAL; // RQ8
                        end
                    end
                    default:
                        fault_reg <= qr_seq_pkg::F_NORMAL;
                endcase
            end
        end
    end

    // Oscillator steering outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cap_to_fault_timer      <= 1'b0;
            osc_freq_clamp          <= 1'b0;
            variable_frequency_mode <= 1'b0;
        end
        else if (clk_en)
        begin
            cap_to_fault_timer      <= run_reg && err_lvl; // RQ10
            osc_freq_clamp          <= lvl[qr_seq_pkg::IN_TAKE] && !err_lvl; // RQ4
            variable_frequency_mode <= !borderline_mode; // RQ5
        end
    end

    // Switch cycle counter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pulses_reg <= '0;
        else if (clk_en && start_now)
            pulses_reg <= pulses_reg + 16'h0001;
    end

    // Register select from a bus address
    function automatic qr_seq_pkg::reg_sel_t reg_decode(input logic [11:0] addr);
        if (addr == qr_seq_pkg::CTRL_ADDR)
            return qr_seq_pkg::R_CTRL;
        else if (addr == qr_seq_pkg::STATUS_ADDR)
            return qr_seq_pkg::R_STATUS;
        else if (addr == qr_seq_pkg::PULSES_ADDR)
            return qr_seq_pkg::R_PULSES;
        else
            return qr_seq_pkg::R_NONE;
    endfunction : reg_decode

    assign bus_access = psel && penable && pready;

    // APB slave: ready one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end
        else if (clk_en)
        begin
            pready  <= psel && penable && !pready;
            pslverr <= 1'b0;
            prdata  <= '0;
            if (psel && penable && !pready)
            begin
                case (reg_decode(paddr))
                    qr_seq_pkg::R_CTRL:
                        prdata <= pwrite ? 32'h00000000 : ctrl_reg;
                    qr_seq_pkg::R_STATUS:
                    begin
                        if (!pwrite)
                        begin
                            prdata[qr_seq_pkg::ST_GATE]    <= gate_drive;
                            prdata[qr_seq_pkg::ST_RUN]     <= run_reg;
                            prdata[qr_seq_pkg::ST_OV]      <= ov_latched_reg;
                            prdata[qr_seq_pkg::ST_FAULT+:2] <= fault_reg;
                            prdata[qr_seq_pkg::ST_VAR]     <= !borderline_mode;
                            prdata[qr_seq_pkg::ST_TIMEOUT] <= timeout_reg;
                            prdata[qr_seq_pkg::ST_ERR]     <= err_lvl;
                            prdata[qr_seq_pkg::ST_OSC]     <= osc_latched_reg;
                        end
                    end
                    qr_seq_pkg::R_PULSES:
                        prdata <= pwrite ? 32'h00000000 : {16'h0000, pulses_reg};
                    default:
                        pslverr <= 1'b1;
                endcase
            end
        end
    end

    // Control register write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_reg <= qr_seq_pkg::CTRL_RESET;
        else if (clk_en && bus_access && pwrite && reg_decode(paddr) == qr_seq_pkg::R_CTRL)
            ctrl_reg <= {31'h00000000, pwdata[qr_seq_pkg::CTRL_EN]};
    end

    // Checks on sequencing and protection
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_idle_ready;
        clk_en && seq_reg == qr_seq_pkg::S_IDLE && pulse_allow;
    endsequence

    sequence s_trip_on;
        clk_en && pulse_allow && seq_reg == qr_seq_pkg::S_ON && cur_lvl;
    endsequence

    a_borderline_start: assert property ( // RQ1
        s_idle_ready ##0 (borderline_mode && zc_rise) |=> gate_drive ##0 seq_reg == qr_seq_pkg::S_BLANK)
        else $error("borderline zero-cross did not start switch");

    a_var_waits_osc: assert property ( // RQ2
        s_idle_ready ##0 (!borderline_mode && !osc_latched_reg && !(timeout_reg && cap_event))
        |=> !gate_drive)
        else $error("frequency mode started without latched pulse");

    a_timeout_restart: assert property ( // RQ3
        s_idle_ready ##0 (timeout_reg && cap_event) |=> gate_drive)
        else $error("timeout restart missed");

    a_blank_ignore: assert property ( // RQ18
        clk_en && pulse_allow && seq_reg == qr_seq_pkg::S_BLANK |=> gate_drive)
        else $error("gate dropped during blanking");

    a_trip_ends_on: assert property ( // RQ6
        s_trip_on |=> !gate_drive ##0 seq_reg == qr_seq_pkg::S_IDLE)
        else $error("current trip did not end on period");

    a_window_suppress: assert property ( // RQ7
        clk_en && run_reg && fault_reg == qr_seq_pkg::F_TIMING && err_lvl && window_end
        |=> fault_reg == qr_seq_pkg::F_SUPPRESS)
        else $error("fault window expiry did not suppress");

    a_suppress_no_gate: assert property ( // RQ8
        clk_en && fault_reg == qr_seq_pkg::F_SUPPRESS |=> !gate_drive)
        else $error("gate pulsed during suppression");

    a_error_clears: assert property ( // RQ13
        clk_en && fault_reg == qr_seq_pkg::F_TIMING && !err_lvl |=> fault_reg == qr_seq_pkg::F_NORMAL)
        else $error("cleared error did not return to normal");

    a_err_routes_cap: assert property ( // RQ10
        clk_en && run_reg && err_lvl |=> cap_to_fault_timer && !osc_freq_clamp)
        else $error("capacitor not routed on error");

    a_ov_latch: assert property ( // RQ15
        clk_en && stop_lvl && ov_hit |=> ov_latched_reg ##1 (!gate_drive || !clk_en))
        else $error("overvoltage did not latch off");

    a_ov_hold: assert property ( // RQ16
        clk_en && ov_latched_reg && stop_lvl |=> ov_latched_reg)
        else $error("overvoltage latch cleared above stop");

    a_startup_source: assert property ( // RQ14
        clk_en && !stop_lvl |=> startup_source_on && !run_reg)
        else $error("startup source off below stop threshold");

    a_gate_unpowered: assert property ( // RQ19
        clk_en && !run_reg |=> !gate_drive)
        else $error("gate active before startup");
endmodule : qr_switch_sequencer

// *** verilog/qr_seq_pkg.sv ***
// Constants and types shared by the quasi-resonant switch sequencer
// Contract
// RQ1 - Borderline mode: zero-cross rise turns switch on
// RQ2 - Frequency mode: latch oscillator pulse, await zero-cross
// RQ3 - Demag timeout restarts on next capacitor event
// RQ4 - Error above takeover holds oscillator at maximum
// RQ5 - Below takeover frequency falls, demag sync kept
// RQ6 - Current-sense trip ends each on period
// RQ7 - Fault lasting one window stops switch pulses
// RQ8 - Burst: one window on, eight windows off
// RQ9 - Recovery ends suppression at startup threshold
// RQ10 - Error routes capacitor to fault timer, borderline
// RQ11 - Fault window counts capacitor ramp cycles
// RQ12 - Error flag follows feedback leaving regulation
// RQ13 - Error clearing early avoids pulse suppression
// RQ14 - Startup source hysteresis between stop and startup
// RQ15 - Overvoltage trip latches all switching off
// RQ16 - Overvoltage latch clears below stop threshold
// RQ17 - External circuit may drive overvoltage pin
// RQ18 - Current sense ignored during blanking window
// RQ19 - Gate low, timers cleared before startup; fault window counters keep counting while fault_reg is F_SUPPRESS
// RQ20 - Comparator outputs sampled as synchronized inputs
package qr_seq_pkg;
    // Timing
    localparam int         CLK_PERIOD_NS    = 20;
    localparam int         TIMEOUT_NS       = 4000;
    localparam int         BLANK_NS         = 200;
    localparam int         FAULT_WINDOW_MS  = 128;
    localparam int         SUPPRESS_WINDOWS = 8;
    localparam logic [7:0] TIMEOUT_CYC      = 8'(TIMEOUT_NS / CLK_PERIOD_NS);
    localparam logic [3:0] BLANK_CYC        = 4'((BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [2:0] SUPPRESS_LAST    = 3'(SUPPRESS_WINDOWS - 1);

    // Sampled input positions
    localparam int NUM_IN   = 10;
    localparam int IN_ZC    = 0;
    localparam int IN_CUR   = 1;
    localparam int IN_ERR   = 2;
    localparam int IN_OVV   = 3;
    localparam int IN_OVEXT = 4;
    localparam int IN_START = 5;
    localparam int IN_STOP  = 6;
    localparam int IN_TAKE  = 7;
    localparam int IN_OSC   = 8;
    localparam int IN_RAMP  = 9;

    // Register map
    localparam logic [11:0] CTRL_ADDR   = 12'h000;
    localparam logic [11:0] STATUS_ADDR = 12'h004;
    localparam logic [11:0] PULSES_ADDR = 12'h008;
    localparam logic [31:0] CTRL_RESET  = 32'h00000001;
    localparam int          CTRL_EN     = 0;

    // Status fields
    localparam int ST_GATE    = 0;
    localparam int ST_RUN     = 1;
    localparam int ST_OV      = 2;
    localparam int ST_FAULT   = 3;
    localparam int ST_VAR     = 5;
    localparam int ST_TIMEOUT = 6;
    localparam int ST_ERR     = 7;
    localparam int ST_OSC     = 8;

    localparam logic STARTUP_SRC_RESET = 1'b1;

    typedef enum logic [1:0] {S_IDLE, S_BLANK, S_ON} seq_state_t;
    typedef enum logic [1:0] {F_NORMAL, F_TIMING, F_SUPPRESS} fault_state_t;
    typedef enum logic [1:0] {R_CTRL, R_STATUS, R_PULSES, R_NONE} reg_sel_t;
endpackage : qr_seq_pkg

// *** verilog/input_sampler.sv ***
// Two-stage sampler with rising-edge detect for comparator outputs
`timescale 1ns/10ps
module input_sampler
(
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         clk_en,
    input  wire logic [qr_seq_pkg::NUM_IN-1:0] raw,
    output logic      [qr_seq_pkg::NUM_IN-1:0] level,
    output logic      [qr_seq_pkg::NUM_IN-1:0] rise
);
    logic [qr_seq_pkg::NUM_IN-1:0] stage1_reg;
    logic [qr_seq_pkg::NUM_IN-1:0] prev_reg;

    // First stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stage1_reg <= '0;
            level      <= '0;
            prev_reg   <= '0;
        end
        else if (clk_en)
        begin
            stage1_reg <= raw; // RQ20
            level      <= stage1_reg;
            prev_reg   <= level;
        end
    end

    // Edge from the settled stages
    always_comb
    begin
        rise = level & ~prev_reg;
    end
endmodule : input_sampler

// *** tb/flyback_stage.sv ***
// Flyback stage model: primary current ramp and auxiliary winding ring
`timescale 1ns/10ps
module flyback_stage
(
    input  wire logic pclk,
    input  wire logic gate_drive,
    input  wire logic early,
    input  wire logic damp,
    output logic      zero_cross,
    output logic      current_trip
);
    int on_cnt = 0;
    int off_cnt = 0;

    // Current reaches setpoint after the ramp time, early mode trips after two cycles
    always @(posedge pclk)
    begin
        on_cnt <= gate_drive ? on_cnt + 1 : 0;
        current_trip <= gate_drive && on_cnt >= (early ? 2 : 14);
    end

    // Ring after switch off gives a zero-cross rise every 32 cycles, dying out when damped
    always @(posedge pclk)
    begin
        off_cnt <= gate_drive ? 0 : off_cnt + 1;
        zero_cross <= !gate_drive && (off_cnt % 32) inside {[20:23]} && !(damp && off_cnt >= 128);
    end
endmodule : flyback_stage

// *** tb/quasi_resonant_switch_sequencer_bench.sv ***
// Self-checking bench for the switch sequencer
`timescale 1ns/10ps
module quasi_resonant_switch_sequencer_bench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, early = 0, damp = 0;
    logic clk_en = 1;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, se, zero_cross, current_trip, gate_drive, startup_source_on;
    logic cap_to_fault_timer, osc_freq_clamp, variable_frequency_mode;
    logic error_flag = 0, vcc_overvoltage = 0, overvoltage_trip = 0, startup_threshold = 0;
    logic stop_threshold = 0, takeover_high = 0, osc_pulse = 0, timing_capacitor_ramp = 0;
    int err_count = 0, checked = 0, n;

    // Clock
    always #10 pclk = ~pclk;

    qr_switch_sequencer #(.RAMPS_PER_WINDOW(16'h0004)) u_qr_switch_sequencer (.pclk, .presetn,
        .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .zero_cross, .current_trip, .error_flag, .vcc_overvoltage, .overvoltage_trip,
        .startup_threshold, .stop_threshold, .takeover_high, .osc_pulse, .timing_capacitor_ramp,
        .gate_drive, .startup_source_on, .cap_to_fault_timer, .osc_freq_clamp,
        .variable_frequency_mode);
    flyback_stage u_flyback_stage (.pclk, .gate_drive, .early, .damp, .zero_cross, .current_trip);

    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // APB transfer, held until pready is sampled high, then one idle edge
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task wait_gate(input logic lvl, input int lim);
        n = 0;
        while (gate_drive !== lvl && n < lim)
        begin
            @(posedge pclk);
            n++;
        end
    endtask : wait_gate

    // Counts cycles with the gate on after any pulse in flight ends
    task quiet(input int cyc);
        wait_gate(1'b0, 50);
        n = 0;
        repeat (cyc)
        begin
            @(posedge pclk);
            if (gate_drive !== 1'b0)
                n++;
        end
    endtask : quiet

    task ramps(input int cnt);
        repeat (cnt)
        begin
            timing_capacitor_ramp <= 1'b1;
            @(posedge pclk);
            timing_capacitor_ramp <= 1'b0;
            repeat (3) @(posedge pclk);
        end
    endtask : ramps

    task t_reset;
        chk("gate", gate_drive, 0);
        chk("source", startup_source_on, 1);
        apb(qr_seq_pkg::CTRL_ADDR, 1'b0, 0);
        chk("ctrl", rd, qr_seq_pkg::CTRL_RESET);
        apb(qr_seq_pkg::CTRL_ADDR, 1'b1, 32'hFFFFFFFE);
        apb(qr_seq_pkg::CTRL_ADDR, 1'b0, 0);
        chk("ctrl wr", rd, 0);
        apb(qr_seq_pkg::CTRL_ADDR, 1'b1, 32'h00000001);
        apb(12'h0FC, 1'b0, 0);
        chk("slverr", se, 1);
    endtask : t_reset

    task t_border;
        clk_en <= 1'b0;
        startup_threshold <= 1'b1;
        stop_threshold <= 1'b1;
        takeover_high <= 1'b1;
        repeat (5) @(posedge pclk);
        chk("frozen", startup_source_on, 1);
        clk_en <= 1'b1;
        wait_gate(1'b1, 300);
        chk("gate on", gate_drive, 1);
        wait_gate(1'b0, 100);
        chk("on time", 32'(n inside {[14:20]}), 1);
        chk("source", startup_source_on, 0);
        early <= 1'b1;
        wait_gate(1'b1, 300);
        wait_gate(1'b0, 100);
        chk("blanked", 32'(n inside {[qr_seq_pkg::BLANK_CYC:qr_seq_pkg::BLANK_CYC+4]}), 1);
        early <= 1'b0;
    endtask : t_border

    task t_vco;
        takeover_high <= 1'b1;
        repeat (5) @(posedge pclk);
        chk("clamp", osc_freq_clamp, 1);
        takeover_high <= 1'b0;
        osc_pulse <= 1'b1;
        repeat (5) @(posedge pclk);
        osc_pulse <= 1'b0;
        chk("varfreq", variable_frequency_mode, 1);
        wait_gate(1'b1, 300);
        chk("varfreq gate", gate_drive, 1);
        damp <= 1'b1;
        wait_gate(1'b0, 100);
        repeat (qr_seq_pkg::TIMEOUT_CYC + 130) @(posedge pclk);
        chk("no restart", gate_drive, 0);
        osc_pulse <= 1'b1;
        repeat (6) @(posedge pclk);
        chk("timeout gate", gate_drive, 1);
        osc_pulse <= 1'b0;
        damp <= 1'b0;
    endtask : t_vco

    task t_fault;
        error_flag <= 1'b1;
        repeat (5) @(posedge pclk);
        chk("route", cap_to_fault_timer, 1);
        chk("varfreq off", variable_frequency_mode, 0);
        ramps(2);
        error_flag <= 1'b0;
        takeover_high <= 1'b1;
        repeat (5) @(posedge pclk);
        chk("route off", cap_to_fault_timer, 0);
        wait_gate(1'b1, 300);
        chk("no burst", gate_drive, 1);
        error_flag <= 1'b1;
        ramps(6);
        quiet(150);
        chk("suppress", n, 0);
        error_flag <= 1'b0;
        startup_threshold <= 1'b0;
        repeat (5) @(posedge pclk);
        startup_threshold <= 1'b1;
        wait_gate(1'b1, 300);
        chk("resume", gate_drive, 1);
    endtask : t_fault

    task t_ov(input int pin);
        if (pin == 0)
            overvoltage_trip <= 1'b1;
        else
            vcc_overvoltage <= 1'b1;
        repeat (4) @(posedge pclk);
        overvoltage_trip <= 1'b0;
        vcc_overvoltage <= 1'b0;
        quiet(150);
        chk("latched", n, 0);
        stop_threshold <= 1'b0;
        startup_threshold <= 1'b0;
        repeat (5) @(posedge pclk);
        stop_threshold <= 1'b1;
        startup_threshold <= 1'b1;
        wait_gate(1'b1, 300);
        chk("restart", gate_drive, 1);
    endtask : t_ov

    task wrap_up;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up

    // Watchdog against a hang
    initial
    begin
        #200000;
        err_count++;
        wrap_up();
    end

    // Main sequence
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_border();
        t_vco();
        t_fault();
        t_ov(0);
        t_ov(1);
        wrap_up();
    end
endmodule : quasi_resonant_switch_sequencer_bench
